// File: rtl/twsde_pkg.sv
package twsde_pkg;
	localparam int AW = 12;
	localparam int CW = 13;
	localparam logic [AW-1:0] TASK_STOP_OFF = 12'h014;
	localparam logic [AW-1:0] TASK_SUSPEND_OFF = 12'h01C;
	localparam logic [AW-1:0] TASK_RESUME_OFF = 12'h020;
	localparam logic [AW-1:0] TASK_ARM_RX_OFF = 12'h030;
	localparam logic [AW-1:0] TASK_ARM_TX_OFF = 12'h034;
	localparam logic [AW-1:0] EVT_STOPPED_OFF = 12'h104;
	localparam logic [AW-1:0] EVT_ERROR_OFF = 12'h124;
	localparam logic [AW-1:0] EVT_RX_BEGUN_OFF = 12'h14C;
	localparam logic [AW-1:0] EVT_TX_BEGUN_OFF = 12'h150;
	localparam logic [AW-1:0] EVT_WRITE_OFF = 12'h164;
	localparam logic [AW-1:0] EVT_READ_OFF = 12'h168;
	localparam logic [AW-1:0] SHORTCUT_OFF = 12'h200;
	localparam logic [AW-1:0] MATCH_OFF = 12'h4D4;
	localparam logic [AW-1:0] ENABLE_OFF = 12'h500;
	localparam logic [AW-1:0] RX_PTR_OFF = 12'h534;
	localparam logic [AW-1:0] RX_MAX_OFF = 12'h538;
	localparam logic [AW-1:0] RX_DONE_OFF = 12'h53C;
	localparam logic [AW-1:0] TX_PTR_OFF = 12'h544;
	localparam logic [AW-1:0] TX_MAX_OFF = 12'h548;
	localparam logic [AW-1:0] TX_DONE_OFF = 12'h54C;
	localparam logic [AW-1:0] SLV_ADDR0_OFF = 12'h588;
	localparam logic [AW-1:0] SLV_ADDR1_OFF = 12'h58C;
	localparam logic [AW-1:0] MATCH_CFG_OFF = 12'h594;
	localparam logic [AW-1:0] OVR_CHAR_OFF = 12'h5C0;
	// Event bit positions inside the sticky event vector
	localparam int EV_STOPPED = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_RX_BEGUN = 2;
	localparam int EV_TX_BEGUN = 3;
	localparam int EV_WRITE = 4;
	localparam int EV_READ = 5;
	localparam int EV_N = 6;
	// Field positions
	localparam int ENABLE_BIT = 0;
	localparam int SHORT_READ_SUSPEND_BIT = 0;
	localparam int CFG_ADDR0_BIT = 0;
	localparam int CFG_ADDR1_BIT = 1;
	localparam logic RW_READ = 1'b1;
	localparam logic ACK_LVL = 1'b0;
	// Reset values
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic [CW-1:0] CNT_RST = 13'h0000;
	localparam logic [6:0] SLV_ADDR_RST = 7'h00;
	localparam logic [1:0] MATCH_CFG_RST = 2'h1;
	localparam logic [7:0] OVR_CHAR_RST = 8'h00;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_AACK = 4'h2,
		ST_TXLD = 4'h3,
		ST_TX = 4'h4,
		ST_MACK = 4'h5,
		ST_RX = 4'h6,
		ST_RACK = 4'h7,
		ST_WAIT = 4'h8,
		ST_STOPPING = 4'h9
	} twsde_state_t;
endpackage

// File: rtl/twsde_core.sv
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// Operation
// - Direction bit one means master reads, zero means master writes.
// - Address acknowledge drives data low to accept, leaves high to refuse.
// - Incoming address compared against up to two configured addresses.
// - Read command acknowledged only on match; read event at acknowledge.
// - Write command acknowledged only on match; write event at acknowledge.
// - Commands recognised after a start from any state once enabled.
// - Arm-transmit sets flag; read waits stretching clock until flag set.
// - Entering transmit raises transmit-begun event and clears the flag.
// - Arm-receive sets flag; write waits stretching clock until flag set.
// - Entering receive raises receive-begun event and clears the flag.
// - Repeated start during transmit or receive goes straight to address reception.
// - Bus stop ends transfer, raises stopped, clears flag, goes idle.
// - Transmit sends DMA-fetched bytes on master-supplied clock edges.
// - Beyond transmit maximum, over-read character is sent with error event.
// - Received bytes beyond maximum are dropped, refused, error raised.
// - Every received byte is acknowledged while buffer has room.
// - Pointer and maximum copied to working registers at begun event.
// - Bytes sent or received readable in done-count registers afterwards.
// - Stopped event waits for the last DMA access to finish.
// - Stop task ends transfer without bus stop, releases bus, goes idle.
// - Suspend holds clock low next chance; resume releases; read shortcut.
module twsde_core (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [twsde_pkg::AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic dma_req,
	output logic dma_we,
	output logic [31:0] dma_addr,
	output logic [7:0] dma_wdata,
	input wire logic [7:0] dma_rdata,
	input wire logic dma_ack
);
	twsde_pkg::twsde_state_t st_r;
	logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;
	logic en_r, short_r, tx_prep_r, rx_prep_r, susp_r;
	logic [6:0] addr0_r, addr1_r;
	logic [1:0] cfg_r;
	logic [7:0] ovr_char_r, sh_r, dma_wdata_r;
	logic [31:0] tx_ptr_r, rx_ptr_r, wptr_r, rd_val, rdata_r;
	logic [twsde_pkg::CW-1:0] tx_max_r, rx_max_r, tx_done_r, rx_done_r;
	logic [twsde_pkg::CW-1:0] wmax_r, wcnt_r;
	logic [twsde_pkg::EV_N-1:0] evt_r, ev_pulse_r;
	logic match_r, mode_tx_r, ent_r, dma_req_r, dma_we_r, sda_oe_r, scl_oe_r;
	logic [3:0] bcnt_r;

	// Bus conditions seen on synchronised pins
	wire scl_rise = scl_s_r & ~scl_p_r;
	wire scl_fall = ~scl_s_r & scl_p_r;
	wire start_c = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
	wire stop_c = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

	// Task strobes
	wire wr1 = reg_wr & reg_wdata[0];
	wire t_stop = wr1 & (reg_addr == twsde_pkg::TASK_STOP_OFF);
	wire t_susp = wr1 & (reg_addr == twsde_pkg::TASK_SUSPEND_OFF);
	wire t_resume = wr1 & (reg_addr == twsde_pkg::TASK_RESUME_OFF);
	wire t_arm_rx = wr1 & (reg_addr == twsde_pkg::TASK_ARM_RX_OFF);
	wire t_arm_tx = wr1 & (reg_addr == twsde_pkg::TASK_ARM_TX_OFF);

	// Address match against both slots
	wire hit0 = cfg_r[twsde_pkg::CFG_ADDR0_BIT] & (sh_r[7:1] == addr0_r);
	wire hit1 = cfg_r[twsde_pkg::CFG_ADDR1_BIT] & (sh_r[7:1] == addr1_r);
	wire is_read = (sh_r[0] == twsde_pkg::RW_READ);
	wire room = (wcnt_r < wmax_r);
	wire tx_have = (tx_max_r != twsde_pkg::CNT_RST);
	wire busy_xfer = (st_r != twsde_pkg::ST_IDLE) &&
		(st_r != twsde_pkg::ST_ADDR) && ent_r;

	// Stretch only while low; transmit load holds until its bit is out
	wire st_aack = (st_r == twsde_pkg::ST_AACK);
	wire st_txld = (st_r == twsde_pkg::ST_TXLD);
	wire st_rack = (st_r == twsde_pkg::ST_RACK);
	wire hold_w = en_r & ((st_aack & (~ent_r | susp_r)) | st_txld |
		(st_rack & (dma_req_r | susp_r)));

	// Event clear: writing zero to an event register
	wire clr_w = reg_wr & ~reg_wdata[0];
	wire [twsde_pkg::EV_N-1:0] ev_clr = {twsde_pkg::EV_N{clr_w}} & {
		(reg_addr == twsde_pkg::EVT_READ_OFF),
		(reg_addr == twsde_pkg::EVT_WRITE_OFF),
		(reg_addr == twsde_pkg::EVT_TX_BEGUN_OFF),
		(reg_addr == twsde_pkg::EVT_RX_BEGUN_OFF),
		(reg_addr == twsde_pkg::EVT_ERROR_OFF),
		(reg_addr == twsde_pkg::EVT_STOPPED_OFF)};

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign dma_req = dma_req_r;
	assign dma_we = dma_we_r;
	assign dma_addr = wptr_r;
	assign dma_wdata = dma_wdata_r;
	assign reg_rdata = rdata_r;

	// Pins cross into core_clk through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_p_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_p_r <= sda_s_r;
		end
	end

	// Pull only once the line is seen low, so no short high pulse is cut
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_oe_r <= 1'b0;
		end else begin
			scl_oe_r <= hold_w & (scl_oe_r | ~scl_s_r);
		end
	end

	// Software registers; setup belongs to the disabled period
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_r <= 1'b0;
			short_r <= 1'b0;
			{addr0_r, addr1_r} <= {2{twsde_pkg::SLV_ADDR_RST}};
			cfg_r <= twsde_pkg::MATCH_CFG_RST;
			ovr_char_r <= twsde_pkg::OVR_CHAR_RST;
			{tx_ptr_r, rx_ptr_r} <= {2{twsde_pkg::PTR_RST}};
			{tx_max_r, rx_max_r} <= {2{twsde_pkg::CNT_RST}};
		end else if (reg_wr) begin
			unique case (reg_addr)
				twsde_pkg::ENABLE_OFF: en_r <= reg_wdata[twsde_pkg::ENABLE_BIT];
				twsde_pkg::SHORTCUT_OFF:
					short_r <= reg_wdata[twsde_pkg::SHORT_READ_SUSPEND_BIT];
				twsde_pkg::SLV_ADDR0_OFF: addr0_r <= reg_wdata[6:0];
				twsde_pkg::SLV_ADDR1_OFF: addr1_r <= reg_wdata[6:0];
				twsde_pkg::MATCH_CFG_OFF: cfg_r <= reg_wdata[1:0];
				twsde_pkg::OVR_CHAR_OFF: ovr_char_r <= reg_wdata[7:0];
				twsde_pkg::TX_PTR_OFF: tx_ptr_r <= reg_wdata;
				twsde_pkg::RX_PTR_OFF: rx_ptr_r <= reg_wdata;
				twsde_pkg::TX_MAX_OFF: tx_max_r <= reg_wdata[twsde_pkg::CW-1:0];
				twsde_pkg::RX_MAX_OFF: rx_max_r <= reg_wdata[twsde_pkg::CW-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events: a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			evt_r <= '0;
		end else begin
			evt_r <= (evt_r & ~ev_clr) | ev_pulse_r;
		end
	end

	always_comb begin
		unique case (reg_addr)
			twsde_pkg::EVT_STOPPED_OFF: rd_val = {31'h0, evt_r[0]};
			twsde_pkg::EVT_ERROR_OFF: rd_val = {31'h0, evt_r[1]};
			twsde_pkg::EVT_RX_BEGUN_OFF: rd_val = {31'h0, evt_r[2]};
			twsde_pkg::EVT_TX_BEGUN_OFF: rd_val = {31'h0, evt_r[3]};
			twsde_pkg::EVT_WRITE_OFF: rd_val = {31'h0, evt_r[4]};
			twsde_pkg::EVT_READ_OFF: rd_val = {31'h0, evt_r[5]};
			twsde_pkg::SHORTCUT_OFF: rd_val = {31'h0, short_r};
			twsde_pkg::MATCH_OFF: rd_val = {31'h0, match_r};
			twsde_pkg::ENABLE_OFF: rd_val = {31'h0, en_r};
			twsde_pkg::RX_PTR_OFF: rd_val = rx_ptr_r;
			twsde_pkg::RX_MAX_OFF: rd_val = {19'h0, rx_max_r};
			twsde_pkg::RX_DONE_OFF: rd_val = {19'h0, rx_done_r};
			twsde_pkg::TX_PTR_OFF: rd_val = tx_ptr_r;
			twsde_pkg::TX_MAX_OFF: rd_val = {19'h0, tx_max_r};
			twsde_pkg::TX_DONE_OFF: rd_val = {19'h0, tx_done_r};
			twsde_pkg::SLV_ADDR0_OFF: rd_val = {25'h0, addr0_r};
			twsde_pkg::SLV_ADDR1_OFF: rd_val = {25'h0, addr1_r};
			twsde_pkg::MATCH_CFG_OFF: rd_val = {30'h0, cfg_r};
			twsde_pkg::OVR_CHAR_OFF: rd_val = {24'h0, ovr_char_r};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
		end
	end

	// Protocol engine, DMA and the flags it shares with software
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= twsde_pkg::ST_IDLE;
			{tx_prep_r, rx_prep_r} <= 2'h0;
			susp_r <= 1'b0;
			sh_r <= 8'h00;
			bcnt_r <= 4'h0;
			match_r <= 1'b0;
			mode_tx_r <= 1'b0;
			ent_r <= 1'b0;
			sda_oe_r <= 1'b0;
			wptr_r <= twsde_pkg::PTR_RST;
			{wmax_r, wcnt_r} <= {2{twsde_pkg::CNT_RST}};
			{tx_done_r, rx_done_r} <= {2{twsde_pkg::CNT_RST}};
			dma_req_r <= 1'b0;
			dma_we_r <= 1'b0;
			dma_wdata_r <= 8'h00;
			ev_pulse_r <= '0;
		end else begin
			ev_pulse_r <= '0;
			tx_prep_r <= tx_prep_r | t_arm_tx;
			rx_prep_r <= rx_prep_r | t_arm_rx;
			susp_r <= t_susp | (susp_r & ~t_resume);
			// A DMA access runs to its end even if the bus moves on
			if (dma_req_r && dma_ack) begin
				dma_req_r <= 1'b0;
				wptr_r <= wptr_r + 32'h0000_0001;
				wcnt_r <= wcnt_r + 13'h0001;
				if (!dma_we_r) begin
					sh_r <= dma_rdata;
				end
			end
			if (!en_r) begin
				st_r <= twsde_pkg::ST_IDLE;
				sda_oe_r <= 1'b0;
				ent_r <= 1'b0;
			end else if (t_stop) begin
				sda_oe_r <= 1'b0;
				st_r <= twsde_pkg::ST_STOPPING;
			end else if (start_c) begin
				if (busy_xfer) begin
					if (mode_tx_r) begin
						tx_done_r <= wcnt_r;
					end else begin
						rx_done_r <= wcnt_r;
					end
				end
				// Restart skips idle and goes straight to address reception
				ent_r <= 1'b0;
				sda_oe_r <= 1'b0;
				bcnt_r <= 4'h0;
				st_r <= twsde_pkg::ST_ADDR;
			end else if (stop_c) begin
				sda_oe_r <= 1'b0;
				st_r <= busy_xfer ? twsde_pkg::ST_STOPPING :
					twsde_pkg::ST_IDLE;
			end else begin
				unique case (st_r)
					twsde_pkg::ST_IDLE: ;
					twsde_pkg::ST_ADDR: begin
						if (scl_rise) begin
							sh_r <= {sh_r[6:0], sda_s_r};
							bcnt_r <= bcnt_r + 4'h1;
						end else if (scl_fall && bcnt_r == 4'h8) begin
							bcnt_r <= 4'h0;
							if (hit0 || hit1) begin
								st_r <= twsde_pkg::ST_AACK;
								sda_oe_r <= (twsde_pkg::ACK_LVL == 1'b0);
								match_r <= hit1 & ~hit0;
								mode_tx_r <= is_read;
								if (is_read) begin
									ev_pulse_r[twsde_pkg::EV_READ] <= 1'b1;
									if (short_r) begin
										susp_r <= 1'b1;
									end
								end else begin
									ev_pulse_r[twsde_pkg::EV_WRITE] <= 1'b1;
								end
							end else begin
								st_r <= twsde_pkg::ST_WAIT;
							end
						end
					end
					twsde_pkg::ST_AACK: begin
						if (!ent_r && (mode_tx_r ? tx_prep_r : rx_prep_r)) begin
							ent_r <= 1'b1;
							wcnt_r <= twsde_pkg::CNT_RST;
							if (mode_tx_r) begin
								tx_prep_r <= t_arm_tx;
								ev_pulse_r[twsde_pkg::EV_TX_BEGUN] <= 1'b1;
								wptr_r <= tx_ptr_r;
								wmax_r <= tx_max_r;
								if (tx_have) begin
									dma_req_r <= 1'b1;
									dma_we_r <= 1'b0;
								end else begin
									sh_r <= ovr_char_r;
									ev_pulse_r[twsde_pkg::EV_ERROR] <= 1'b1;
								end
							end else begin
								rx_prep_r <= t_arm_rx;
								ev_pulse_r[twsde_pkg::EV_RX_BEGUN] <= 1'b1;
								wptr_r <= rx_ptr_r;
								wmax_r <= rx_max_r;
							end
						end else if (scl_fall && ent_r) begin
							sda_oe_r <= 1'b0;
							bcnt_r <= 4'h0;
							st_r <= mode_tx_r ? twsde_pkg::ST_TXLD :
								twsde_pkg::ST_RX;
						end
					end
					twsde_pkg::ST_TXLD: begin
						if (!dma_req_r && !susp_r) begin
							sda_oe_r <= ~sh_r[7];
							bcnt_r <= 4'h0;
							st_r <= twsde_pkg::ST_TX;
						end
					end
					twsde_pkg::ST_TX: begin
						if (scl_fall) begin
							if (bcnt_r == 4'h7) begin
								sda_oe_r <= 1'b0;
								st_r <= twsde_pkg::ST_MACK;
							end else begin
								sh_r <= {sh_r[6:0], 1'b0};
								sda_oe_r <= ~sh_r[6];
								bcnt_r <= bcnt_r + 4'h1;
							end
						end
					end
					twsde_pkg::ST_MACK: begin
						if (scl_rise) begin
							if (sda_s_r != twsde_pkg::ACK_LVL) begin
								st_r <= twsde_pkg::ST_WAIT;
							end else if (room) begin
								dma_req_r <= 1'b1;
								dma_we_r <= 1'b0;
							end else begin
								sh_r <= ovr_char_r;
								ev_pulse_r[twsde_pkg::EV_ERROR] <= 1'b1;
							end
						end else if (scl_fall) begin
							st_r <= twsde_pkg::ST_TXLD;
						end
					end
					twsde_pkg::ST_RX: begin
						if (scl_rise) begin
							sh_r <= {sh_r[6:0], sda_s_r};
							bcnt_r <= bcnt_r + 4'h1;
						end else if (scl_fall && bcnt_r == 4'h8) begin
							bcnt_r <= 4'h0;
							st_r <= twsde_pkg::ST_RACK;
							if (room) begin
								sda_oe_r <= 1'b1;
								dma_req_r <= 1'b1;
								dma_we_r <= 1'b1;
								dma_wdata_r <= sh_r;
							end else begin
								sda_oe_r <= 1'b0;
								ev_pulse_r[twsde_pkg::EV_ERROR] <= 1'b1;
							end
						end
					end
					twsde_pkg::ST_RACK: begin
						if (scl_fall) begin
							sda_oe_r <= 1'b0;
							st_r <= twsde_pkg::ST_RX;
						end
					end
					twsde_pkg::ST_WAIT: ;
					twsde_pkg::ST_STOPPING: begin
						if (!dma_req_r) begin
							ev_pulse_r[twsde_pkg::EV_STOPPED] <= 1'b1;
							if (ent_r && mode_tx_r) begin
								tx_done_r <= wcnt_r;
								tx_prep_r <= t_arm_tx;
							end else if (ent_r) begin
								rx_done_r <= wcnt_r;
								rx_prep_r <= t_arm_rx;
							end
							ent_r <= 1'b0;
							st_r <= twsde_pkg::ST_IDLE;
						end
					end
					default: st_r <= twsde_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule

// File: verification/twsde_assertions.sv
`timescale 1ns/100ps
module twsde_assertions (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [twsde_pkg::AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic dma_req,
	input wire logic dma_we,
	input wire logic [31:0] dma_addr,
	input wire logic [7:0] dma_wdata,
	input wire logic [7:0] dma_rdata,
	input wire logic dma_ack
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// A task written while the clock is being stretched
	wire logic task_hit = reg_wr && reg_wdata[0] && scl_oe;

	AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("pin output value not low");
	// Data may only move while the clock is low, else it reads as start/stop
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line changed while clock high");
	AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	AST_DMA_HOLD: assert property (dma_req && !dma_ack |=> dma_req &&
		$stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata))
		else $error("memory request changed before acknowledge");
	AST_DMA_DROP: assert property (dma_ack && dma_req |=> !dma_req)
		else $error("memory request kept after acknowledge");
	AST_RX_ACK_DMA: assert property ($rose(dma_req) && dma_we |-> ##[0:3] sda_oe)
		else $error("stored byte not acknowledged");
	AST_ARM_TX: assert property (task_hit &&
		reg_addr == twsde_pkg::TASK_ARM_TX_OFF |-> ##[1:40] !scl_oe)
		else $error("clock kept low after transmit arm");
	AST_RESUME: assert property (task_hit &&
		reg_addr == twsde_pkg::TASK_RESUME_OFF |-> ##[1:40] !scl_oe)
		else $error("clock kept low after resume");
	AST_STOP_TASK: assert property (task_hit &&
		reg_addr == twsde_pkg::TASK_STOP_OFF |-> ##[1:40] !scl_oe && !sda_oe)
		else $error("bus not released after stop task");
	cover property ($rose(scl_oe));
	cover property (dma_ack && dma_we);
	cover property (dma_ack && !dma_we);
endmodule

bind twsde_core twsde_assertions twsde_assertions_i (.core_clk, .rstn,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i, .scl_o,
	.scl_oe, .sda_i, .sda_o, .sda_oe, .dma_req, .dma_we, .dma_addr,
	.dma_wdata, .dma_rdata, .dma_ack);

// File: verification/twsde_master_model.sv
`timescale 1ns/100ps
module twsde_master_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_lo,
	output logic sda_lo
);
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	// Low 500 ns, high 300 ns; the rise waits on the wire, so stretching works
	task automatic bit_x(input logic b, output logic r);
		#50;
		sda_lo = ~b;
		#450;
		scl_lo = 1'b0;
		wait (scl);
		#300;
		r = sda;
		scl_lo = 1'b1;
	endtask
	// Most significant bit first, then the acknowledge slot
	task automatic xbyte(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic ra);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(a, ra);
	endtask
	task automatic start();
		#50;
		sda_lo = 1'b0;
		#450;
		scl_lo = 1'b0;
		wait (scl);
		#200;
		sda_lo = 1'b1;
		#300;
		scl_lo = 1'b1;
	endtask
	task automatic stop();
		#50;
		sda_lo = 1'b1;
		#450;
		scl_lo = 1'b0;
		wait (scl);
		#200;
		sda_lo = 1'b0;
		#500;
	endtask
endmodule

// File: verification/twsde_tb_top.sv
`timescale 1ns/100ps
module twsde_tb_top;
	logic core_clk, rstn, reg_wr, reg_rd, dma_ack, ra;
	logic [twsde_pkg::AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, dma_addr;
	logic scl_o, scl_oe, sda_o, sda_oe, dma_req, dma_we, m_scl_lo, m_sda_lo;
	logic [7:0] dma_wdata, dma_rdata, ram [256], sent [$];
	int miscompares = 0;
	int n_tests = 0;
	int lat = 0;
	localparam logic [7:0] ORC_V = 8'hC3;
	// Pull-ups on both wires: a released line reads high
	wire logic scl_w = !(m_scl_lo || (scl_oe && !scl_o));
	wire logic sda_w = !(m_sda_lo || (sda_oe && !sda_o));

	twsde_core twsde_core_i (.core_clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .scl_i(scl_w), .scl_o, .scl_oe,
		.sda_i(sda_w), .sda_o, .sda_oe, .dma_req, .dma_we, .dma_addr,
		.dma_wdata, .dma_rdata, .dma_ack);
	twsde_master_model twsde_master_model_i (.scl(scl_w), .sda(sda_w),
		.scl_lo(m_scl_lo), .sda_lo(m_sda_lo));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Memory with random stalls; read data toggles outside the answer
	always @(posedge core_clk) begin
		dma_ack <= 1'b0;
		dma_rdata <= ~dma_rdata;
		if (dma_req && !dma_ack) begin
			if (lat == 0) begin
				dma_ack <= 1'b1;
				dma_rdata <= ram[dma_addr[7:0]];
				if (dma_we) begin
					ram[dma_addr[7:0]] <= dma_wdata;
				end
				lat <= $urandom_range(3, 0);
			end else begin
				lat <= lat - 1;
			end
		end
	end

	task automatic chk(input string n, input logic [31:0] got,
		input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [twsde_pkg::AW-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [twsde_pkg::AW-1:0] a,
		input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(n, reg_rdata, e);
	endtask
	// Checks the events selected by m, then clears all six
	task automatic ev_chk(input logic [5:0] e, input logic [5:0] m);
		logic [twsde_pkg::AW-1:0] offs [6];
		offs = '{twsde_pkg::EVT_STOPPED_OFF, twsde_pkg::EVT_ERROR_OFF,
			twsde_pkg::EVT_RX_BEGUN_OFF, twsde_pkg::EVT_TX_BEGUN_OFF,
			twsde_pkg::EVT_WRITE_OFF, twsde_pkg::EVT_READ_OFF};
		for (int i = 0; i < 6; i++) begin
			if (m[i]) begin
				rd_chk($sformatf("event %0d", i), offs[i], 32'(e[i]));
			end
			wr(offs[i], 32'h0);
		end
	endtask
	// Waits for a stretch, confirms it holds, then triggers a task
	task automatic hold_then(input logic [twsde_pkg::AW-1:0] a);
		for (int i = 0; i < 400 && scl_oe !== 1'b1; i++) begin
			@(posedge core_clk);
		end
		repeat (20) @(posedge core_clk);
		#1;
		chk("stretch", 32'(scl_oe), 32'h1);
		wr(a, 32'h1);
	endtask
	task automatic cmd(input logic [6:0] a, input logic rw, output logic r);
		logic [7:0] q;
		twsde_master_model_i.start();
		twsde_master_model_i.xbyte({a, rw}, 1'b1, q, r);
	endtask
	task automatic wbytes(input int n, input int mx);
		logic [7:0] q, d;
		logic r;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			sent.push_back(d);
			twsde_master_model_i.xbyte(d, 1'b1, q, r);
			chk("write ack", 32'(r), 32'(i >= mx));
		end
	endtask
	task automatic rbytes(input int p, input int n, input int mx);
		logic [7:0] q;
		logic r;
		for (int i = 0; i < n; i++) begin
			twsde_master_model_i.xbyte(8'hFF, i == n - 1, q, r);
			chk("read", 32'(q), 32'(i < mx ? ram[p + i] : ORC_V));
		end
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// About 2000 cycles are needed; the margin covers long stretches
	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		finish_test();
	end

	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		dma_ack = 1'b0;
		dma_rdata = 8'h00;
		void'($urandom(15));
		foreach (ram[i]) begin
			ram[i] = 8'($urandom);
		end
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		rd_chk("enable", twsde_pkg::ENABLE_OFF, 32'h0);
		rd_chk("unmapped", 12'h7FC, 32'h0);
		wr(twsde_pkg::SLV_ADDR0_OFF, 32'h2A);
		wr(twsde_pkg::SLV_ADDR1_OFF, 32'h51);
		wr(twsde_pkg::MATCH_CFG_OFF, 32'h3);
		wr(twsde_pkg::OVR_CHAR_OFF, 32'(ORC_V));
		wr(twsde_pkg::ENABLE_OFF, 32'h1);
		$display("test setup done");
		cmd(7'h33, 1'b0, ra);
		chk("foreign address", 32'(ra), 32'h1);
		twsde_master_model_i.stop();
		ev_chk(6'h00, 6'h3E);
		$display("test foreign address done");
		wr(twsde_pkg::RX_PTR_OFF, 32'h10);
		wr(twsde_pkg::RX_MAX_OFF, 32'h3);
		wr(twsde_pkg::TASK_ARM_RX_OFF, 32'h1);
		cmd(7'h51, 1'b0, ra);
		chk("write address", 32'(ra), 32'h0);
		wbytes(5, 3);
		twsde_master_model_i.stop();
		repeat (20) @(posedge core_clk);
		for (int i = 0; i < 3; i++) begin
			chk("rx byte", 32'(ram[16 + i]), 32'(sent[i]));
		end
		rd_chk("rx count", twsde_pkg::RX_DONE_OFF, 32'h3);
		rd_chk("match", twsde_pkg::MATCH_OFF, 32'h1);
		ev_chk(6'h17, 6'h3F);
		$display("test write overflow done");
		wr(twsde_pkg::TX_PTR_OFF, 32'h40);
		wr(twsde_pkg::TX_MAX_OFF, 32'h2);
		fork
			begin
				cmd(7'h2A, 1'b1, ra);
				chk("read address", 32'(ra), 32'h0);
				rbytes(8'h40, 4, 2);
				twsde_master_model_i.stop();
			end
			begin
				hold_then(twsde_pkg::TASK_ARM_TX_OFF);
				repeat (30) @(posedge core_clk);
				wr(twsde_pkg::TX_PTR_OFF, 32'h80);
			end
		join
		repeat (20) @(posedge core_clk);
		rd_chk("tx count", twsde_pkg::TX_DONE_OFF, 32'h2);
		ev_chk(6'h2B, 6'h3F);
		$display("test read over-read done");
		sent.delete();
		fork
			begin
				cmd(7'h2A, 1'b0, ra);
				wbytes(1, 0);
				twsde_master_model_i.stop();
			end
			hold_then(twsde_pkg::TASK_STOP_OFF);
		join
		ev_chk(6'h11, 6'h3F);
		$display("test stop task done");
		sent.delete();
		wr(twsde_pkg::RX_PTR_OFF, 32'h60);
		wr(twsde_pkg::RX_MAX_OFF, 32'h4);
		wr(twsde_pkg::TX_PTR_OFF, 32'h20);
		wr(twsde_pkg::TX_MAX_OFF, 32'h1);
		wr(twsde_pkg::TASK_ARM_RX_OFF, 32'h1);
		wr(twsde_pkg::TASK_ARM_TX_OFF, 32'h1);
		wr(twsde_pkg::SHORTCUT_OFF, 32'h1);
		fork
			begin
				cmd(7'h2A, 1'b1, ra);
				chk("read address", 32'(ra), 32'h0);
				rbytes(8'h20, 2, 1);
				cmd(7'h2A, 1'b0, ra);
				chk("restart address", 32'(ra), 32'h0);
				wbytes(1, 4);
				twsde_master_model_i.stop();
			end
			hold_then(twsde_pkg::TASK_RESUME_OFF);
		join
		wr(twsde_pkg::SHORTCUT_OFF, 32'h0);
		repeat (20) @(posedge core_clk);
		chk("rx byte", 32'(ram[8'h60]), 32'(sent[0]));
		rd_chk("tx count", twsde_pkg::TX_DONE_OFF, 32'h1);
		rd_chk("rx count", twsde_pkg::RX_DONE_OFF, 32'h1);
		ev_chk(6'h3F, 6'h3F);
		$display("test suspend and restart done");
		wr(twsde_pkg::TASK_STOP_OFF, 32'h1);
		repeat (4) @(posedge core_clk);
		rd_chk("stopped", twsde_pkg::EVT_STOPPED_OFF, 32'h1);
		wr(twsde_pkg::ENABLE_OFF, 32'h0);
		rd_chk("disable", twsde_pkg::ENABLE_OFF, 32'h0);
		$display("test stop and disable done");
		finish_test();
	end
endmodule
